// file: shared/panadv_cfg.svh
/*
 * Constants of the auto-negotiation advertisement register bank.
 * Assumes inclusion by bare name from the package and the design modules.
 */
// Contract
// - Loader values overwrite register after reset, reload.
// - Bit 13 advertises remote fault, resets 0.
// - Bit 11 advertises asymmetric pause.
// - Bit 10 advertises symmetric pause.
// - Port 1 external mode: pause bits reset 0.
// - Manual strap 0: symmetric 1, asymmetric follows strap.
// - Manual strap 1: both pause bits reset 0.
// - Bit 8 default 0 external, else 1.
// - Bit 7 resets to 1 always.
// - Bit 6 default: 1 external, else autoneg or (!speed and duplex).
// - Bit 5 default: 1 external, else autoneg or not speed.
// - Bits 4:0 selector reset to 802.3 code.
// - Straps captured at chip reset deassertion.
`ifndef PANADV_CFG_SVH
`define PANADV_CFG_SVH

// ==========================================================
// Register map
`define PANADV_IDX_ADVERT   5'h04
`define PANADV_RESET_WORD   16'h0000
`define PANADV_WR_MASK      16'h3DFF

// ==========================================================
// Field positions
`define PANADV_B_RFAULT     13
`define PANADV_B_RSVD12     12
`define PANADV_B_ASYM       11
`define PANADV_B_SYM        10
`define PANADV_B_FD100      8
`define PANADV_B_HD100      7
`define PANADV_B_FD10       6
`define PANADV_B_HD10       5
`define PANADV_SEL_MSB      4
`define PANADV_SEL_LSB      0
`define PANADV_SEL_8023     5'h01

// ==========================================================
// Ports and strap capture
`define PANADV_NPORTS       2
`define PANADV_PORT1        1'h0
`define PANADV_STRAP_W      11

`endif

// file: shared/panadv_pkg.sv
/*
 * Types of the auto-negotiation advertisement register bank.
 * Assumes panadv_cfg.svh for all numeric constants.
 */
`include "panadv_cfg.svh"

package panadv_pkg;

   // ==========================================================
   // Strap set of one port
   typedef struct packed {
      logic autoneg;
      logic speed;
      logic duplex;
      logic manual_flow_control_pin_setting;
      logic full_duplex_flow_control_pin_setting;
   } panadv_strap_t;

   // ==========================================================
   // Management access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        port;
      logic [4:0]  index;
      logic [15:0] wdata;
   } panadv_mgmt_t;

   // ==========================================================
   // Loader write
   typedef struct packed {
      logic        valid;
      logic        port;
      logic [15:0] data;
   } panadv_load_t;

   // ==========================================================
   // Capture sequencer states
   typedef enum logic [3:0] {
      PANADV_FILL1 = 4'h1,
      PANADV_FILL2 = 4'h2,
      PANADV_GRAB  = 4'h4,
      PANADV_DONE  = 4'h8
   } panadv_cap_state_t;

endpackage : panadv_pkg

// file: rtl/panadv_strap_latch.sv
/*
 * Strap synchroniser and capture at reset release.
 * Assumes strap pins are stable around chip reset deassertion.
 */
`include "panadv_cfg.svh"

module panadv_strap_latch (
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         reset,
   // Raw strap pins
   input  wire logic [`PANADV_STRAP_W-1:0]   pins,
   // Captured straps
   output logic      [`PANADV_STRAP_W-1:0]   cap_q,
   output logic                              cap_stb_q
);

   // ==========================================================
   // Two-flop synchroniser
   logic [`PANADV_STRAP_W-1:0]  meta_q;
   logic [`PANADV_STRAP_W-1:0]  sync_q;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pins;
         sync_q <= meta_q;
      end
   end

   // ==========================================================
   // Capture sequencer
   panadv_pkg::panadv_cap_state_t  state_q;
   panadv_pkg::panadv_cap_state_t  state_d;
   logic [`PANADV_STRAP_W-1:0]     cap_d;
   logic                           cap_stb_d;

   always_comb begin
      state_d   = state_q;
      cap_d     = cap_q;
      cap_stb_d = 1'b0;
      case (state_q)
         panadv_pkg::PANADV_FILL1: begin
            state_d = panadv_pkg::PANADV_FILL2;
         end
         panadv_pkg::PANADV_FILL2: begin
            state_d = panadv_pkg::PANADV_GRAB;
         end
         panadv_pkg::PANADV_GRAB: begin
            state_d   = panadv_pkg::PANADV_DONE;
            cap_d     = sync_q;
            cap_stb_d = 1'b1;
         end
         panadv_pkg::PANADV_DONE: begin
            state_d = panadv_pkg::PANADV_DONE;
         end
         default: begin
            state_d = panadv_pkg::PANADV_FILL1;
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q   <= panadv_pkg::PANADV_FILL1;
         cap_q     <= '0;
         cap_stb_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         cap_q     <= cap_d;
         cap_stb_q <= cap_stb_d;
      end
   end

endmodule : panadv_strap_latch

// file: rtl/panadv_reg.sv
/*
 * Per-port auto-negotiation advertisement registers of two PHYs,
 * with strap-derived defaults, loader overwrite and management access.
 * Assumes management and loader requests come from logic on clock,
 * and strap pins come from outside and are synchronised here.
 * Assumes strap pins settle before chip reset is released and stay put
 * for the three clocks of the capture sequence.
 * Assumes the loader follows each reload with its own words.
 * Assumes one management strobe per cycle at most.
 */
`include "panadv_cfg.svh"

module panadv_reg (
   // Clock and reset
   input  wire logic                                 clock,
   input  wire logic                                 reset,
   // Strap pins
   input  wire panadv_pkg::panadv_strap_t [1:0]      strap_pins,
   input  wire logic                                 port1_external_mode,
   // Configuration loader
   input  wire logic                                 reload,
   input  wire panadv_pkg::panadv_load_t             loader_req,
   // Management access
   input  wire panadv_pkg::panadv_mgmt_t             mgmt_req,
   output logic      [15:0]                          mgmt_rdata_q,
   output logic                                      mgmt_rvalid_q,
   // Advertised words and status
   output logic      [1:0][15:0]                     advert_q,
   output logic                                      defaults_ready_q
);

   // ==========================================================
   // Strap capture
   logic [`PANADV_STRAP_W-1:0]        cap_raw;
   logic                              cap_stb;
   panadv_pkg::panadv_strap_t [1:0]   cap_straps;
   logic                              cap_ext;

   panadv_strap_latch u_strap_latch (
      .clock     (clock),
      .reset     (reset),
      .pins      ({port1_external_mode, strap_pins}),
      .cap_q     (cap_raw),
      .cap_stb_q (cap_stb)
   );

   assign cap_straps = cap_raw[`PANADV_STRAP_W-2:0];
   assign cap_ext    = cap_raw[`PANADV_STRAP_W-1];

   // ==========================================================
   // Asymmetric pause default of one port
   function automatic logic panadv_asym (
      input logic                      ext,
      input panadv_pkg::panadv_strap_t s
   );
      logic r;
      if (ext) begin
         r = 1'b0;
      end else if (s.manual_flow_control_pin_setting) begin
         r = 1'b0;
      end else begin
         r = s.full_duplex_flow_control_pin_setting;
      end
      return r;
   endfunction : panadv_asym

   // ==========================================================
   // Symmetric pause default of one port
   function automatic logic panadv_sym (
      input logic                      ext,
      input panadv_pkg::panadv_strap_t s
   );
      logic r;
      if (ext) begin
         r = 1'b0;
      end else if (s.manual_flow_control_pin_setting) begin
         r = 1'b0;
      end else begin
         r = 1'b1;
      end
      return r;
   endfunction : panadv_sym

   // ==========================================================
   // Default word of one port
   function automatic logic [15:0] panadv_default (
      input logic                      is_port1,
      input logic                      ext_mode,
      input panadv_pkg::panadv_strap_t s
   );
      logic [15:0] w;
      logic        ext;
      w   = `PANADV_RESET_WORD;
      ext = is_port1 & ext_mode;
      w[`PANADV_B_RFAULT] = 1'b0;
      w[`PANADV_B_RSVD12] = 1'b0;
      w[`PANADV_B_ASYM] = panadv_asym(ext, s);
      w[`PANADV_B_SYM]  = panadv_sym(ext, s);
      w[`PANADV_B_FD100] = ~ext;
      w[`PANADV_B_HD100] = 1'b1;
      w[`PANADV_B_FD10]  = ext | s.autoneg | (~s.speed & s.duplex);
      w[`PANADV_B_HD10]  = ext | s.autoneg | ~s.speed;
      w[`PANADV_SEL_MSB:`PANADV_SEL_LSB] = `PANADV_SEL_8023;
      return w;
   endfunction : panadv_default

   // ==========================================================
   // Reload honoured only once straps are held
   logic  reload_ok;

   assign reload_ok = reload & defaults_ready_q;

   // ==========================================================
   // Default application control
   logic  apply_q;
   logic  apply_d;
   logic  ready_d;

   always_comb begin
      apply_d = cap_stb | reload_ok;
      ready_d = defaults_ready_q | cap_stb;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         apply_q          <= 1'b0;
         defaults_ready_q <= 1'b0;
      end else begin
         apply_q          <= apply_d;
         defaults_ready_q <= ready_d;
      end
   end

   // ==========================================================
   // Management decode
   logic  mgmt_hit;

   assign mgmt_hit = (mgmt_req.index == `PANADV_IDX_ADVERT);

   // ==========================================================
   // Write data conditioning
   logic [15:0]  wr_word;
   logic [15:0]  load_word;

   assign wr_word   = mgmt_req.wdata & `PANADV_WR_MASK;
   assign load_word = loader_req.data & `PANADV_WR_MASK;

   // ==========================================================
   // Per-port register
   genvar p;
   generate
      for (p = 0; p < `PANADV_NPORTS; p = p + 1) begin : g_port
         logic         is_p1;
         logic         load_hit;
         logic         wr_hit;
         logic [15:0]  dflt_q;
         logic [15:0]  dflt_d;
         logic [15:0]  adv_d;

         // Port role and request decode
         assign is_p1    = (p == 0);
         assign load_hit = loader_req.valid & (loader_req.port == 1'(p));
         assign wr_hit   = mgmt_req.wr & mgmt_hit & (mgmt_req.port == 1'(p));

         // Default word, held from capture for later reloads
         always_comb begin
            dflt_d = dflt_q;
            if (cap_stb) begin
               dflt_d = panadv_default(is_p1, cap_ext, cap_straps[p]);
            end
         end

         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               dflt_q <= `PANADV_RESET_WORD;
            end else begin
               dflt_q <= dflt_d;
            end
         end

         // Next word: loader, then defaults, then software
         always_comb begin
            adv_d = advert_q[p];
            if (load_hit) begin
               adv_d = load_word;
            end else if (apply_q) begin
               adv_d = dflt_q;
            end else if (wr_hit) begin
               adv_d = wr_word;
            end
         end

         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               advert_q[p] <= `PANADV_RESET_WORD;
            end else begin
               advert_q[p] <= adv_d;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read path
   logic [15:0]  rdata_d;
   logic         rvalid_d;

   always_comb begin
      rvalid_d = mgmt_req.rd;
      rdata_d  = mgmt_rdata_q;
      if (mgmt_req.rd) begin
         if (mgmt_hit) begin
            rdata_d = advert_q[mgmt_req.port] & `PANADV_WR_MASK;
         end else begin
            rdata_d = `PANADV_RESET_WORD;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mgmt_rdata_q  <= `PANADV_RESET_WORD;
         mgmt_rvalid_q <= 1'b0;
      end else begin
         mgmt_rdata_q  <= rdata_d;
         mgmt_rvalid_q <= rvalid_d;
      end
   end

endmodule : panadv_reg

// file: tb/panadv_chk.sv
/* Assertion checker on the ports of panadv_reg.
 * Assumes panadv_pkg compiled first; bound at the foot. */
module panadv_chk (
   // Watched ports
   input wire logic                     clock,
   input wire logic                     reset,
   input wire logic                     port1_external_mode,
   input wire logic                     reload,
   input wire panadv_pkg::panadv_load_t loader_req,
   input wire panadv_pkg::panadv_mgmt_t mgmt_req,
   input wire logic [1:0][15:0]         advert_q,
   input wire logic                     defaults_ready_q,
   input wire logic [15:0]              mgmt_rdata_q,
   input wire logic                     mgmt_rvalid_q
);
   timeunit 1ns;
   timeprecision 100ps;
   // ====
   // Properties
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   property p_rsvd;
      ((advert_q[0] | advert_q[1]) & 16'hC200) == 16'h0000;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_wr;
      mgmt_req.wr && mgmt_req.index == 5'h04 && !loader_req.valid && !$past(reload) && $past(defaults_ready_q)
      |=> advert_q[$past(mgmt_req.port)] == ($past(mgmt_req.wdata) & 16'h3DFF);
   endproperty
   a_wr: assert property (p_wr) else $error("write not stored");
   property p_load;
      loader_req.valid |=> advert_q[$past(loader_req.port)] == ($past(loader_req.data) & 16'h3DFF);
   endproperty
   a_load: assert property (p_load) else $error("loader word not stored");
   property p_sel;
      $rose(defaults_ready_q) |=> advert_q[0][4:0] == 5'h01 && advert_q[1][4:0] == 5'h01;
   endproperty
   a_sel: assert property (p_sel) else $error("selector default wrong");
   property p_fd100;
      $rose(defaults_ready_q) |=> advert_q[0][8] == !port1_external_mode && advert_q[1][8];
   endproperty
   a_fd100: assert property (p_fd100) else $error("fd100 default wrong");
   property p_hd100;
      reload && defaults_ready_q ##1 !loader_req.valid |=> advert_q[0][7] && advert_q[1][7];
   endproperty
   a_hd100: assert property (p_hd100) else $error("hd100 not restored");
   property p_ready;
      $past(reset) && !reset |-> !defaults_ready_q [*4] ##1 defaults_ready_q;
   endproperty
   a_ready: assert property (p_ready) else $error("strap capture timing wrong");
   property p_ext;
      $rose(defaults_ready_q) && port1_external_mode |=> advert_q[0][11:10] == 2'h0 && advert_q[0][6:5] == 2'h3;
   endproperty
   a_ext: assert property (p_ext) else $error("external mode default wrong");
   property p_rvalid;
      mgmt_req.rd |=> mgmt_rvalid_q && (mgmt_rdata_q & 16'hC200) == 16'h0000;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer missing or reserved bit set");
   // ====
   // Covers
   c_ext: cover property ($rose(defaults_ready_q) && port1_external_mode);
   c_reload: cover property (reload && defaults_ready_q);
   c_load: cover property (loader_req.valid);
endmodule : panadv_chk

bind panadv_reg panadv_chk panadv_chk_i (.clock, .reset, .port1_external_mode, .reload, .loader_req, .mgmt_req,
   .advert_q, .defaults_ready_q, .mgmt_rdata_q, .mgmt_rvalid_q);

// file: tb/panadv_host.sv
/* Management host model issuing register requests.
 * Assumes calls start just after a clock edge. */
module panadv_host (
   // Requests and answers
   input wire logic             clock,
   output panadv_pkg::panadv_mgmt_t mgmt_req,
   input wire logic [15:0]      mgmt_rdata_q,
   input wire logic             mgmt_rvalid_q
);
   timeunit 1ns;
   timeprecision 100ps;
   initial mgmt_req = '0;
   // ====
   // One access, read data in q
   task automatic access(input logic w, input logic p, input logic [4:0] ix, input logic [15:0] d,
                         output logic [15:0] q);
      int n;
      mgmt_req = {w, ~w, p, ix, w ? (d & 16'hEFFF) : d};
      @(posedge clock);
      #2 mgmt_req = {2'h0, ~p, ~ix, ~mgmt_req.wdata};
      for (n = 0; n < 4 && !w && mgmt_rvalid_q !== 1'b1; n++) @(posedge clock);
      q = (mgmt_rvalid_q === 1'b1) ? mgmt_rdata_q : 16'hXXXX;
      @(posedge clock);
      #2;
   endtask : access
endmodule : panadv_host

// file: tb/panadv_reg_bench.sv
/* Self-checking bench of panadv_reg.
 * Assumes panadv_chk bound and panadv_host as management host. */
module panadv_reg_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, reset, port1_external_mode, reload, defaults_ready_q, mgmt_rvalid_q;
   panadv_pkg::panadv_strap_t [1:0] strap_pins;
   panadv_pkg::panadv_load_t loader_req;
   panadv_pkg::panadv_mgmt_t mgmt_req;
   logic [15:0] mgmt_rdata_q, q, w;
   logic [1:0][15:0] advert_q;
   int error_cnt = 0, total_checks = 0, seed = 6825, i, n, p;
   int model[2];
   panadv_reg panadv_reg_i (.clock, .reset, .strap_pins, .port1_external_mode, .reload, .loader_req, .mgmt_req,
      .mgmt_rdata_q, .mgmt_rvalid_q, .advert_q, .defaults_ready_q);
   panadv_host panadv_host_i (.clock, .mgmt_req, .mgmt_rdata_q, .mgmt_rvalid_q);
   // ====
   // Reference defaults
   function automatic int dflt(input int p, input logic ext, input panadv_pkg::panadv_strap_t s);
      logic m, f;
      m = s.manual_flow_control_pin_setting;
      f = s.full_duplex_flow_control_pin_setting;
      if (p == 0 && ext) return 'hE1;
      return (int'(!m) << 10) | (int'(!m && f) << 11) | 'h181 | (int'(s.autoneg || (!s.speed && s.duplex)) << 6)
             | (int'(s.autoneg || !s.speed) << 5);
   endfunction : dflt
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic report_and_stop();
      if (error_cnt == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   // ====
   // Stimulus
   initial begin
      clock = 0;
      forever #10 clock = ~clock;
   end
   initial begin
      {reset, reload, loader_req, port1_external_mode, strap_pins} = {1'b1, 19'h0, 11'h0};
      for (i = 0; i < 8; i++) begin
         reset = 1;
         strap_pins = 10'($random(seed));
         strap_pins[i % 2].manual_flow_control_pin_setting = i[1];
         port1_external_mode = i[2];
         repeat (6) @(posedge clock);
         #2 reset = 0;
         for (n = 0; n < 20 && defaults_ready_q !== 1'b1; n++) begin
            @(posedge clock);
            #2;
         end
         if (n == 20) begin
            error_cnt++;
            report_and_stop();
         end
         repeat (2) @(posedge clock);
         #2;
         for (n = 0; n < 2; n++) begin
            model[n] = dflt(n, i[2], strap_pins[n]);
            check("advert", 16'(model[n]), advert_q[n]);
            panadv_host_i.access(0, n[0], 5'h04, 16'h0, q);
            check("read", 16'(model[n]), q);
         end
         p = i % 2;
         w = 16'($random(seed));
         panadv_host_i.access(1, p[0], 5'h04, w, q);
         check("write", w & 16'h2DFF, advert_q[p]);
         panadv_host_i.access(0, p[0], 5'(i + 5), 16'h0, q);
         check("unmapped", 16'h0000, q);
         w = 16'($random(seed));
         loader_req = {1'b1, ~p[0], w};
         @(posedge clock);
         #2 loader_req = {1'b0, p[0], ~w};
         check("loader", w & 16'h3DFF, advert_q[1 - p]);
         reload = 1;
         @(posedge clock);
         #2 reload = 0;
         repeat (2) @(posedge clock);
         #2;
         for (n = 0; n < 2; n++) check("reload", 16'(model[n]), advert_q[n]);
      end
      report_and_stop();
   end
endmodule : panadv_reg_bench
